// >>> src/vpe_pkg.sv
// What this block does
// - Two overvoltage stages; one setting picks phase-phase or phase-neutral measurement.
// - Overvoltage stage 1 is IDMT, DT or off; stage 2 DT with enable.
// - Overvoltage stage 1 IDMT operates after K/(M-1) seconds.
// - Negative-sequence overvoltage has one DT stage with its own enable.
// - From two line voltages, negative sequence is (Vab - a*Vbc)/3.
// - Negative sequence gives start and trip; speed-up cuts 80 ms to 40 ms.
// - Undervoltage stage 1 IDMT operates after K/(1-M) seconds.
// - Undervoltage outputs answer single-phase or only three-phase conditions.
// - Any-phase mode ORs the three phases; three-phase mode ANDs them.
// - Each undervoltage stage may be inhibited while pole dead is asserted.
// - Pole dead: breaker open, or undercurrent with undervoltage on one phase.
// - Residual voltage is the vector sum of the three phase voltages.
// - Residual stage 1 IDMT or DT, stage 2 DT; own settings each.
// - Residual stage 1 IDMT operates after K/(M-1) seconds.
// - Supervision block suppresses residual start outputs.
// - Each residual stage has a timer-block input inhibiting its delay.
// - Each enabled residual stage drives its own start and trip.
package vpe_pkg;
   localparam int VPE_VW = 16;
   localparam int CLOCK_PERIOD_NS = 10;
   localparam int MS_TICK_NS = 1000000;
   localparam int TICK_CYCLES_DEF = MS_TICK_NS / CLOCK_PERIOD_NS;
   localparam int NPS_TYP_MS = 80;
   localparam int NPS_FAST_MS = 40;
   localparam logic [15:0] NPS_TYP_TICKS = 16'(NPS_TYP_MS);
   localparam logic [15:0] NPS_FAST_TICKS = 16'(NPS_FAST_MS);
   localparam logic signed [11:0] SIN60_Q10 = 12'sh0377;
   localparam logic [15:0] THIRD_Q16 = 16'h5556;
   localparam logic [15:0] VPE_CNT_RST = 16'h0000;
   localparam logic [15:0] VPE_CNT_MAX = 16'hFFFF;
   localparam logic [32:0] VPE_ACC_RST = 33'h0_0000_0000;
   localparam logic [15:0] VPE_MAG_RST = 16'h0000;
   localparam logic VPE_FLAG_RST = 1'b0;
   typedef enum logic [2:0] {
      VPE_MODE_OFF = 3'b001,
      VPE_MODE_DT = 3'b010,
      VPE_MODE_IDMT = 3'b100
   } vpe_mode_e;
endpackage

// >>> src/vpe_stage_if.sv
`timescale 1ns/1ps
interface vpe_stage_if;
   logic enable;
   logic idmt;
   logic cond;
   logic hold;
   logic [15:0] excess;
   logic [15:0] vset;
   logic [15:0] tms;
   logic [15:0] delay;
   logic start;
   logic trip;
   modport owner(output enable, idmt, cond, hold, excess, vset, tms, delay,
                 input start, trip);
   modport timer(input enable, idmt, cond, hold, excess, vset, tms, delay,
                 output start, trip);
endinterface

// >>> src/vpe_phasor_calc.sv
`timescale 1ns/1ps
module vpe_phasor_calc (
   input wire logic clock,
   input wire logic resetn,
   input wire logic use_line_inputs,
   input wire logic signed [15:0] va_re,
   input wire logic signed [15:0] va_im,
   input wire logic signed [15:0] vb_re,
   input wire logic signed [15:0] vb_im,
   input wire logic signed [15:0] vc_re,
   input wire logic signed [15:0] vc_im,
   input wire logic signed [15:0] vab_re,
   input wire logic signed [15:0] vab_im,
   input wire logic signed [15:0] vbc_re,
   input wire logic signed [15:0] vbc_im,
   output logic [15:0] nps_mag,
   output logic [15:0] residual_mag
);
   import vpe_pkg::*;
   logic signed [19:0] ab_re, ab_im, bc_re, bc_im, n_re, n_im, r_re, r_im;
   logic signed [31:0] bc_im_k, bc_re_k;
   logic [20:0] n_root, r_root;
   logic [36:0] n_third;

   function automatic logic [20:0] isqrt(input logic signed [19:0] x, input logic signed [19:0] y);
      logic [41:0] v;
      logic [20:0] root;
      logic [20:0] cand;
      v = 42'(x * x) + 42'(y * y);
      root = 21'h00_0000;
      for (int i = 20; i >= 0; i--) begin
         cand = root | (21'h00_0001 << i);
         if (42'(cand) * 42'(cand) <= v) begin
            root = cand;
         end
      end
      return root;
   endfunction

   always_comb begin
      if (use_line_inputs) begin
         ab_re = 20'(vab_re);
         ab_im = 20'(vab_im);
         bc_re = 20'(vbc_re);
         bc_im = 20'(vbc_im);
      end else begin
         ab_re = 20'(va_re) - 20'(vb_re);
         ab_im = 20'(va_im) - 20'(vb_im);
         bc_re = 20'(vb_re) - 20'(vc_re);
         bc_im = 20'(vb_im) - 20'(vc_im);
      end
   end
   // Vab - a*Vbc with a = -0.5 + j0.866
   assign bc_im_k = 32'(bc_im) * 32'(SIN60_Q10);
   assign bc_re_k = 32'(bc_re) * 32'(SIN60_Q10);
   assign n_re = ab_re + (bc_re >>> 1) + 20'(bc_im_k >>> 10);
   assign n_im = ab_im - 20'(bc_re_k >>> 10) + (bc_im >>> 1);
   // Residual as the vector sum of the phases
   assign r_re = 20'(va_re) + 20'(vb_re) + 20'(vc_re);
   assign r_im = 20'(va_im) + 20'(vb_im) + 20'(vc_im);
   assign n_root = isqrt(n_re, n_im);
   assign r_root = isqrt(r_re, r_im);
   assign n_third = (37'(n_root) * 37'(THIRD_Q16)) >> 16;

   // Magnitudes saturate rather than wrap, so overrange reads as a big voltage
   always_ff @(posedge clock) begin
      if (!resetn) begin
         nps_mag <= VPE_MAG_RST;
         residual_mag <= VPE_MAG_RST;
      end else begin
         nps_mag <= (n_third > 37'(VPE_CNT_MAX)) ? VPE_CNT_MAX : n_third[15:0];
         residual_mag <= (r_root > 21'(VPE_CNT_MAX)) ? VPE_CNT_MAX : r_root[15:0];
      end
   end
endmodule

// >>> src/vpe_stage_timer.sv
`timescale 1ns/1ps
module vpe_stage_timer (
   input wire logic clock,
   input wire logic resetn,
   input wire logic tick,
   vpe_stage_if.timer t
);
   import vpe_pkg::*;
   logic active;
   logic timed_out;
   logic [31:0] goal;
   logic [15:0] cnt_reg;
   logic [32:0] acc_reg;
   logic start_reg;
   logic trip_reg;

   assign active = t.enable && t.cond;
   // Integrating (M-1) per ms against K avoids a divider
   assign goal = 32'(t.tms) * 32'(t.vset);
   assign timed_out = t.idmt ? (acc_reg >= 33'(goal)) : (cnt_reg >= t.delay);

   always_ff @(posedge clock) begin
      if (!resetn || !active || t.hold) begin
         cnt_reg <= VPE_CNT_RST;
      end else if (tick && cnt_reg != VPE_CNT_MAX) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn || !active || t.hold) begin
         acc_reg <= VPE_ACC_RST;
      end else if (tick && !acc_reg[32]) begin
         acc_reg <= acc_reg + 33'(t.excess);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         start_reg <= VPE_FLAG_RST;
         trip_reg <= VPE_FLAG_RST;
      end else begin
         start_reg <= active;
         trip_reg <= active && !t.hold && timed_out;
      end
   end

   assign t.start = start_reg;
   assign t.trip = trip_reg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_disabled_quiet: assert property (!t.enable |=> !t.start && !t.trip)
      else $error("disabled stage drove an output");
   a_trip_has_start: assert property (t.trip |-> t.start)
      else $error("trip without start");
   a_hold_no_trip: assert property (t.hold |=> !t.trip)
      else $error("trip while timer blocked");
   a_dt_zero_delay: assert property (
      (t.enable && t.cond && !t.hold && !t.idmt && t.delay == 16'h0000) |=> t.trip)
      else $error("zero delay stage did not trip");
   a_dt_not_early: assert property (
      (!t.idmt && !$past(active)) |-> (t.delay == 16'h0000 || !t.trip))
      else $error("trip before any delay elapsed");
endmodule

// >>> src/vpe_voltage_protection.sv
`timescale 1ns/1ps
module vpe_voltage_protection #(
   parameter int TICK_CYCLES = vpe_pkg::TICK_CYCLES_DEF
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [2:0][15:0] phase_neutral_mag,
   input wire logic [2:0][15:0] phase_phase_mag,
   input wire logic signed [15:0] va_re,
   input wire logic signed [15:0] va_im,
   input wire logic signed [15:0] vb_re,
   input wire logic signed [15:0] vb_im,
   input wire logic signed [15:0] vc_re,
   input wire logic signed [15:0] vc_im,
   input wire logic signed [15:0] vab_re,
   input wire logic signed [15:0] vab_im,
   input wire logic signed [15:0] vbc_re,
   input wire logic signed [15:0] vbc_im,
   input wire logic nps_from_line_inputs,
   input wire logic ov_use_phase_phase,
   input wire logic ov_three_phase,
   input wire vpe_pkg::vpe_mode_e ov1_mode,
   input wire logic [15:0] ov1_volt,
   input wire logic [15:0] ov1_tms,
   input wire logic [15:0] ov1_delay,
   input wire logic ov2_enable,
   input wire logic [15:0] ov2_volt,
   input wire logic [15:0] ov2_delay,
   input wire logic uv_use_phase_phase,
   input wire logic uv_three_phase,
   input wire vpe_pkg::vpe_mode_e uv1_mode,
   input wire logic [15:0] uv1_volt,
   input wire logic [15:0] uv1_tms,
   input wire logic [15:0] uv1_delay,
   input wire logic uv2_enable,
   input wire logic [15:0] uv2_volt,
   input wire logic [15:0] uv2_delay,
   input wire logic uv1_pole_dead_inhibit,
   input wire logic uv2_pole_dead_inhibit,
   input wire logic breaker_open,
   input wire logic [2:0] phase_undercurrent,
   input wire logic [15:0] pole_dead_volt,
   input wire logic nps_ov_enable,
   input wire logic [15:0] nps_volt,
   input wire logic [15:0] nps_delay,
   input wire logic nps_ov_speedup,
   input wire logic residual_stage1_enable,
   input wire logic residual_stage1_idmt,
   input wire logic [15:0] residual_stage1_volt,
   input wire logic [15:0] residual_stage1_tms,
   input wire logic [15:0] residual_stage1_delay,
   input wire logic residual_stage2_enable,
   input wire logic [15:0] residual_stage2_volt,
   input wire logic [15:0] residual_stage2_delay,
   input wire logic residual_stage1_delay_block,
   input wire logic residual_stage2_delay_block,
   input wire logic vt_supervision_block,
   output logic ov1_start,
   output logic ov1_trip,
   output logic ov2_start,
   output logic ov2_trip,
   output logic uv1_start,
   output logic uv1_trip,
   output logic uv2_start,
   output logic uv2_trip,
   output logic pole_dead,
   output logic nps_ov_start,
   output logic nps_ov_trip,
   output logic residual_stage1_start,
   output logic residual_stage1_trip,
   output logic residual_stage2_start,
   output logic residual_stage2_trip
);
   import vpe_pkg::*;
   localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

   logic [TW-1:0] tick_cnt_reg;
   logic tick_reg;
   logic pole_dead_reg;
   logic [15:0] nps_mag;
   logic [15:0] residual_mag;
   logic [5:0] ov_st, ov_tr, uv_st, uv_tr;
   logic [2:0] pd_phase;

   vpe_stage_if ov_if[6]();
   vpe_stage_if uv_if[6]();
   vpe_stage_if nps_if();
   vpe_stage_if res_if[2]();

   function automatic logic combine(input logic [2:0] v, input logic all3);
      return all3 ? &v : |v;
   endfunction

   // One millisecond time base shared by all stage timers
   always_ff @(posedge clock) begin
      if (!resetn) begin
         tick_cnt_reg <= '0;
         tick_reg <= VPE_FLAG_RST;
      end else if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + TW'(1);
         tick_reg <= 1'b0;
      end
   end

   // Per-phase undercurrent together with undervoltage
   generate
      for (genvar p = 0; p < 3; p++) begin : g_pd
         assign pd_phase[p] = phase_undercurrent[p] && (phase_neutral_mag[p] < pole_dead_volt);
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!resetn) begin
         pole_dead_reg <= VPE_FLAG_RST;
      end else begin
         pole_dead_reg <= breaker_open || (|pd_phase);
      end
   end

   vpe_phasor_calc u_phasor (
      .clock(clock),
      .resetn(resetn),
      .use_line_inputs(nps_from_line_inputs),
      .va_re(va_re),
      .va_im(va_im),
      .vb_re(vb_re),
      .vb_im(vb_im),
      .vc_re(vc_re),
      .vc_im(vc_im),
      .vab_re(vab_re),
      .vab_im(vab_im),
      .vbc_re(vbc_re),
      .vbc_im(vbc_im),
      .nps_mag(nps_mag),
      .residual_mag(residual_mag)
   );

   // Index g: stage g/3, phase g%3
   generate
      for (genvar g = 0; g < 6; g++) begin : g_phase
         localparam int S = g / 3;
         localparam int P = g % 3;
         logic [15:0] ov_v;
         logic [15:0] uv_v;
         logic [15:0] ov_set;
         logic [15:0] uv_set;
         logic uv_inhibit;

         assign ov_v = ov_use_phase_phase ? phase_phase_mag[P] : phase_neutral_mag[P];
         assign uv_v = uv_use_phase_phase ? phase_phase_mag[P] : phase_neutral_mag[P];
         assign ov_set = (S == 0) ? ov1_volt : ov2_volt;
         assign uv_set = (S == 0) ? uv1_volt : uv2_volt;
         assign uv_inhibit = pole_dead_reg &&
                             ((S == 0) ? uv1_pole_dead_inhibit : uv2_pole_dead_inhibit);

         // Stage 2 ignores the IDMT option: DT only
         assign ov_if[g].enable = (S == 0) ? (ov1_mode != VPE_MODE_OFF) : ov2_enable;
         assign ov_if[g].idmt = (S == 0) && (ov1_mode == VPE_MODE_IDMT);
         assign ov_if[g].cond = ov_v > ov_set;
         assign ov_if[g].hold = 1'b0;
         assign ov_if[g].excess = ov_if[g].cond ? (ov_v - ov_set) : VPE_CNT_RST;
         assign ov_if[g].vset = ov_set;
         assign ov_if[g].tms = ov1_tms;
         assign ov_if[g].delay = (S == 0) ? ov1_delay : ov2_delay;

         assign uv_if[g].enable = ((S == 0) ? (uv1_mode != VPE_MODE_OFF) : uv2_enable)
                                  && !uv_inhibit;
         assign uv_if[g].idmt = (S == 0) && (uv1_mode == VPE_MODE_IDMT);
         assign uv_if[g].cond = uv_v < uv_set;
         assign uv_if[g].hold = 1'b0;
         assign uv_if[g].excess = uv_if[g].cond ? (uv_set - uv_v) : VPE_CNT_RST;
         assign uv_if[g].vset = uv_set;
         assign uv_if[g].tms = uv1_tms;
         assign uv_if[g].delay = (S == 0) ? uv1_delay : uv2_delay;

         vpe_stage_timer u_ov (
            .clock(clock),
            .resetn(resetn),
            .tick(tick_reg),
            .t(ov_if[g])
         );
         vpe_stage_timer u_uv (
            .clock(clock),
            .resetn(resetn),
            .tick(tick_reg),
            .t(uv_if[g])
         );

         assign ov_st[g] = ov_if[g].start;
         assign ov_tr[g] = ov_if[g].trip;
         assign uv_st[g] = uv_if[g].start;
         assign uv_tr[g] = uv_if[g].trip;
      end
   endgenerate

   // Zero delay means instantaneous: the inherent time then applies
   assign nps_if.enable = nps_ov_enable;
   assign nps_if.idmt = 1'b0;
   assign nps_if.cond = nps_mag > nps_volt;
   assign nps_if.hold = 1'b0;
   assign nps_if.excess = VPE_CNT_RST;
   assign nps_if.vset = nps_volt;
   assign nps_if.tms = VPE_CNT_RST;
   assign nps_if.delay = (nps_delay != VPE_CNT_RST) ? nps_delay :
                         (nps_ov_speedup ? NPS_FAST_TICKS : NPS_TYP_TICKS);

   vpe_stage_timer u_nps (
      .clock(clock),
      .resetn(resetn),
      .tick(tick_reg),
      .t(nps_if)
   );

   // Supervision blocks the whole stage, so a blocked stage cannot time out
   assign res_if[0].enable = residual_stage1_enable && !vt_supervision_block;
   assign res_if[0].idmt = residual_stage1_idmt;
   assign res_if[0].cond = residual_mag > residual_stage1_volt;
   assign res_if[0].hold = residual_stage1_delay_block;
   assign res_if[0].excess = res_if[0].cond ? (residual_mag - residual_stage1_volt) :
                             VPE_CNT_RST;
   assign res_if[0].vset = residual_stage1_volt;
   assign res_if[0].tms = residual_stage1_tms;
   assign res_if[0].delay = residual_stage1_delay;

   assign res_if[1].enable = residual_stage2_enable && !vt_supervision_block;
   assign res_if[1].idmt = 1'b0;
   assign res_if[1].cond = residual_mag > residual_stage2_volt;
   assign res_if[1].hold = residual_stage2_delay_block;
   assign res_if[1].excess = VPE_CNT_RST;
   assign res_if[1].vset = residual_stage2_volt;
   assign res_if[1].tms = VPE_CNT_RST;
   assign res_if[1].delay = residual_stage2_delay;

   generate
      for (genvar r = 0; r < 2; r++) begin : g_res
         vpe_stage_timer u_res (
            .clock(clock),
            .resetn(resetn),
            .tick(tick_reg),
            .t(res_if[r])
         );
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (!resetn) begin
         ov1_start <= VPE_FLAG_RST;
         ov1_trip <= VPE_FLAG_RST;
         ov2_start <= VPE_FLAG_RST;
         ov2_trip <= VPE_FLAG_RST;
      end else begin
         ov1_start <= combine(ov_st[2:0], ov_three_phase);
         ov1_trip <= combine(ov_tr[2:0], ov_three_phase);
         ov2_start <= combine(ov_st[5:3], ov_three_phase);
         ov2_trip <= combine(ov_tr[5:3], ov_three_phase);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         uv1_start <= VPE_FLAG_RST;
         uv1_trip <= VPE_FLAG_RST;
         uv2_start <= VPE_FLAG_RST;
         uv2_trip <= VPE_FLAG_RST;
      end else begin
         uv1_start <= combine(uv_st[2:0], uv_three_phase);
         uv1_trip <= combine(uv_tr[2:0], uv_three_phase);
         uv2_start <= combine(uv_st[5:3], uv_three_phase);
         uv2_trip <= combine(uv_tr[5:3], uv_three_phase);
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         nps_ov_start <= VPE_FLAG_RST;
         nps_ov_trip <= VPE_FLAG_RST;
         pole_dead <= VPE_FLAG_RST;
      end else begin
         nps_ov_start <= nps_if.start;
         nps_ov_trip <= nps_if.trip;
         pole_dead <= pole_dead_reg;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         residual_stage1_start <= VPE_FLAG_RST;
         residual_stage1_trip <= VPE_FLAG_RST;
         residual_stage2_start <= VPE_FLAG_RST;
         residual_stage2_trip <= VPE_FLAG_RST;
      end else begin
         residual_stage1_start <= res_if[0].start;
         residual_stage1_trip <= res_if[0].trip;
         residual_stage2_start <= res_if[1].start;
         residual_stage2_trip <= res_if[1].trip;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence vts_held;
      vt_supervision_block [*2];
   endsequence
   sequence uv1_inhibited;
      (uv1_pole_dead_inhibit && pole_dead_reg) [*2];
   endsequence
   sequence nps_off;
      !nps_ov_enable [*2];
   endsequence
   sequence ov2_off;
      !ov2_enable [*2];
   endsequence
   sequence res2_held;
      residual_stage2_delay_block [*2];
   endsequence
   sequence pd_no_cause;
      !breaker_open && phase_undercurrent == 3'b000;
   endsequence

   a_resid_vts_block: assert property (vts_held |=>
      !residual_stage1_start && !residual_stage2_start)
      else $error("residual start under supervision block");
   a_uv_pd_inhibit: assert property (uv1_inhibited |=> !uv1_start && !uv1_trip)
      else $error("undervoltage stage 1 active while inhibited");
   a_nps_disabled: assert property (nps_off |=> !nps_ov_start && !nps_ov_trip)
      else $error("negative sequence output while disabled");
   a_pole_dead_brk: assert property (breaker_open |-> ##2 pole_dead)
      else $error("pole dead missed breaker open");
   a_ov_any_or: assert property ((!ov_three_phase && |ov_st[2:0]) |=> ov1_start)
      else $error("any-phase overvoltage start missing");
   a_ov_three_and: assert property ((ov_three_phase && !(&ov_st[2:0])) |=> !ov1_start)
      else $error("three-phase overvoltage start without all phases");
   a_uv_three_and: assert property ((uv_three_phase && !(&uv_tr[5:3])) |=> !uv2_trip)
      else $error("three-phase undervoltage trip without all phases");
   a_tick_period: assert property (tick_reg |=> !tick_reg || TICK_CYCLES == 1)
      else $error("time base ticked twice in a row");
   a_ov2_off_quiet: assert property (ov2_off |=> !ov2_start && !ov2_trip)
      else $error("ov stage 2 active while off");
   a_res2_blk_trip: assert property (res2_held |=> !residual_stage2_trip)
      else $error("residual 2 trip while blocked");
   a_pd_clear: assert property (pd_no_cause |-> ##2 !pole_dead)
      else $error("pole dead without cause");
endmodule

// >>> dv/vpe_vt_src.sv
`timescale 1ns/1ps
// Three-phase source: B and C at amp, A at amp_a, so the residual and
// negative-sequence voltages follow from the single unbalance amp_a - amp
module vpe_vt_src (
   input wire logic [15:0] amp,
   input wire logic [15:0] amp_a,
   output logic signed [15:0] va_re,
   output logic signed [15:0] va_im,
   output logic signed [15:0] vb_re,
   output logic signed [15:0] vb_im,
   output logic signed [15:0] vc_re,
   output logic signed [15:0] vc_im,
   output logic signed [15:0] vab_re,
   output logic signed [15:0] vab_im,
   output logic signed [15:0] vbc_re,
   output logic signed [15:0] vbc_im
);
   logic signed [15:0] s;
   assign s = 16'((32'(amp) * 887) >>> 10);
   assign va_re = amp_a;
   assign va_im = 16'h0000;
   assign vb_re = -16'(amp >> 1);
   assign vb_im = -s;
   assign vc_re = -16'(amp >> 1);
   assign vc_im = s;
   assign vab_re = va_re - vb_re;
   assign vab_im = va_im - vb_im;
   assign vbc_re = vb_re - vc_re;
   assign vbc_im = vb_im - vc_im;
endmodule

// >>> dv/vpe_voltage_protection_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] %0t output mismatch", $time); end end
module vpe_voltage_protection_tb_top;
   import vpe_pkg::*;
   logic clock, resetn;
   logic [2:0][15:0] phase_neutral_mag, phase_phase_mag;
   logic signed [15:0] va_re, va_im, vb_re, vb_im, vc_re, vc_im;
   logic signed [15:0] vab_re, vab_im, vbc_re, vbc_im;
   logic [15:0] amp, amp_a;
   logic nps_from_line_inputs, ov_use_phase_phase, ov_three_phase, ov2_enable;
   vpe_mode_e ov1_mode, uv1_mode;
   logic [15:0] ov1_volt, ov1_tms, ov1_delay, ov2_volt, ov2_delay;
   logic [15:0] uv1_volt, uv1_tms, uv1_delay, uv2_volt, uv2_delay, pole_dead_volt;
   logic uv_use_phase_phase, uv_three_phase, uv2_enable, uv1_pole_dead_inhibit;
   logic uv2_pole_dead_inhibit, breaker_open, nps_ov_enable, nps_ov_speedup;
   logic [2:0] phase_undercurrent;
   logic [15:0] nps_volt, nps_delay, residual_stage1_volt, residual_stage1_tms;
   logic [15:0] residual_stage1_delay, residual_stage2_volt, residual_stage2_delay;
   logic residual_stage1_enable, residual_stage1_idmt, residual_stage2_enable;
   logic residual_stage1_delay_block, residual_stage2_delay_block, vt_supervision_block;
   logic ov1_start, ov1_trip, ov2_start, ov2_trip, uv1_start, uv1_trip, uv2_start;
   logic uv2_trip, pole_dead, nps_ov_start, nps_ov_trip, residual_stage1_start;
   logic residual_stage1_trip, residual_stage2_start, residual_stage2_trip;
   int bad_count = 0, n_checks = 0, cycles = 0;

   vpe_vt_src src_u (.amp, .amp_a, .va_re, .va_im, .vb_re, .vb_im, .vc_re, .vc_im,
      .vab_re, .vab_im, .vbc_re, .vbc_im);
   vpe_voltage_protection #(.TICK_CYCLES(10)) dut_u (.clock, .resetn, .phase_neutral_mag,
      .phase_phase_mag, .va_re, .va_im, .vb_re, .vb_im, .vc_re, .vc_im, .vab_re, .vab_im,
      .vbc_re, .vbc_im, .nps_from_line_inputs, .ov_use_phase_phase, .ov_three_phase,
      .ov1_mode, .ov1_volt, .ov1_tms, .ov1_delay, .ov2_enable, .ov2_volt, .ov2_delay,
      .uv_use_phase_phase, .uv_three_phase, .uv1_mode, .uv1_volt, .uv1_tms, .uv1_delay,
      .uv2_enable, .uv2_volt, .uv2_delay, .uv1_pole_dead_inhibit, .uv2_pole_dead_inhibit,
      .breaker_open, .phase_undercurrent, .pole_dead_volt, .nps_ov_enable, .nps_volt,
      .nps_delay, .nps_ov_speedup, .residual_stage1_enable, .residual_stage1_idmt,
      .residual_stage1_volt, .residual_stage1_tms, .residual_stage1_delay,
      .residual_stage2_enable, .residual_stage2_volt, .residual_stage2_delay,
      .residual_stage1_delay_block, .residual_stage2_delay_block, .vt_supervision_block,
      .ov1_start, .ov1_trip, .ov2_start, .ov2_trip, .uv1_start, .uv1_trip, .uv2_start,
      .uv2_trip, .pole_dead, .nps_ov_start, .nps_ov_trip, .residual_stage1_start,
      .residual_stage1_trip, .residual_stage2_start, .residual_stage2_trip);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task cyc(input int n);
      repeat (n) @(negedge clock);
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Whole run is about 1900 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      resetn = 1'b0;
      phase_neutral_mag = {3{16'h0384}};
      phase_phase_mag = '0;
      {amp, amp_a} = {16'h03E8, 16'h03E8};
      {nps_from_line_inputs, ov_use_phase_phase, ov_three_phase, ov2_enable} = 4'h9;
      {uv_use_phase_phase, uv_three_phase, uv2_enable} = 3'h0;
      {uv1_pole_dead_inhibit, uv2_pole_dead_inhibit, breaker_open} = 3'h0;
      {nps_ov_enable, nps_ov_speedup, vt_supervision_block} = 3'h0;
      {residual_stage1_enable, residual_stage1_idmt, residual_stage2_enable} = 3'h0;
      {residual_stage1_delay_block, residual_stage2_delay_block} = 2'h0;
      phase_undercurrent = 3'h0;
      ov1_mode = VPE_MODE_DT;
      uv1_mode = VPE_MODE_OFF;
      {ov1_volt, ov2_volt, uv1_volt, uv2_volt} = {16'h03E8, 16'h03E8, 16'h01F4, 16'h01F4};
      {ov1_tms, uv1_tms, residual_stage1_tms} = {3{16'h000A}};
      {ov1_delay, ov2_delay, uv1_delay, uv2_delay} = {16'h0003, 16'h0000, 16'h0000, 16'h0000};
      {pole_dead_volt, nps_volt, nps_delay} = {16'h01F4, 16'h01F4, 16'h0000};
      {residual_stage1_volt, residual_stage2_volt} = {2{16'h03E8}};
      {residual_stage1_delay, residual_stage2_delay} = {2{16'h0002}};
      cyc(5);
      resetn = 1'b1;
      cyc(3);
      `CHK(ov1_start, 1'b0)
      phase_neutral_mag[0] = 16'h044C;
      cyc(3);
      `CHK({ov1_start, ov1_trip}, 2'b10)
      cyc(50);
      `CHK(ov1_trip, 1'b1)
      ov_use_phase_phase = 1'b1;
      cyc(3);
      `CHK({ov1_start, ov1_trip}, 2'b00)
      {ov_use_phase_phase, ov_three_phase} = 2'b01;
      cyc(3);
      `CHK({ov1_start, ov2_start}, 2'b00)
      phase_neutral_mag = {3{16'h044C}};
      cyc(3);
      `CHK({ov1_start, ov2_start, ov2_trip}, 3'b111)
      {ov_three_phase, ov2_enable} = 2'b00;
      phase_neutral_mag[2:1] = {2{16'h0384}};
      cyc(3);
      `CHK({ov1_start, ov2_start, ov2_trip}, 3'b100)
      ov1_mode = VPE_MODE_OFF;
      cyc(3);
      `CHK({ov1_start, ov1_trip}, 2'b00)
      ov1_mode = VPE_MODE_IDMT;
      phase_neutral_mag[0] = 16'h07D0;
      cyc(70);
      `CHK({ov1_start, ov1_trip}, 2'b10)
      cyc(70);
      `CHK(ov1_trip, 1'b1)
      ov1_mode = VPE_MODE_OFF;
      phase_neutral_mag = {16'h0384, 16'h0064, 16'h0384};
      uv1_mode = VPE_MODE_DT;
      uv2_enable = 1'b1;
      cyc(3);
      `CHK({uv1_start, uv1_trip, uv2_start, uv2_trip}, 4'b1111)
      uv_three_phase = 1'b1;
      cyc(3);
      `CHK(uv1_start, 1'b0)
      {uv_three_phase, uv1_pole_dead_inhibit, breaker_open} = 3'b011;
      cyc(5);
      `CHK({pole_dead, uv1_start, uv2_start}, 3'b101)
      {breaker_open, phase_undercurrent} = {1'b0, 3'b010};
      cyc(5);
      `CHK({pole_dead, uv1_start}, 2'b10)
      phase_undercurrent = 3'b000;
      cyc(6);
      `CHK({pole_dead, uv1_start}, 2'b01)
      uv1_mode = VPE_MODE_IDMT;
      uv1_volt = 16'h03E8;
      phase_neutral_mag = {16'h04B0, 16'h01F4, 16'h04B0};
      cyc(150);
      `CHK({uv1_start, uv1_trip}, 2'b10)
      cyc(100);
      `CHK(uv1_trip, 1'b1)
      uv1_mode = VPE_MODE_OFF;
      {residual_stage1_enable, residual_stage2_enable, vt_supervision_block} = 3'b111;
      // Scheme logic holds stage 1 delay off while stage 2 runs
      residual_stage1_delay_block = 1'b1;
      {nps_ov_enable, nps_ov_speedup} = 2'b11;
      amp_a = 16'h0BB8;
      cyc(45);
      `CHK({residual_stage1_start, residual_stage2_start}, 2'b00)
      vt_supervision_block = 1'b0;
      cyc(45);
      `CHK({residual_stage1_start, residual_stage1_trip}, 2'b10)
      `CHK({residual_stage2_start, residual_stage2_trip}, 2'b11)
      `CHK({nps_ov_start, nps_ov_trip}, 2'b10)
      cyc(300);
      `CHK(nps_ov_trip, 1'b0)
      cyc(120);
      `CHK(nps_ov_trip, 1'b1)
      amp_a = 16'h03E8;
      {nps_ov_speedup, nps_from_line_inputs} = 2'b00;
      {residual_stage1_idmt, residual_stage1_delay_block, residual_stage2_delay_block} = 3'b101;
      cyc(5);
      amp_a = 16'h0BB8;
      cyc(700);
      `CHK({nps_ov_start, nps_ov_trip}, 2'b10)
      `CHK({residual_stage1_trip, residual_stage2_start, residual_stage2_trip}, 3'b110)
      cyc(200);
      `CHK(nps_ov_trip, 1'b1)
      nps_ov_enable = 1'b0;
      cyc(4);
      `CHK({nps_ov_start, nps_ov_trip}, 2'b00)
      end_of_test();
   end
endmodule
